/* File: hw/pmf_req_table.sv */
`timescale 1ns/1ns
// Small table of outstanding requests, searched by key, hit registered.
module pmf_req_table #(
   parameter int DEPTH = 4,
   parameter int KEY_W = 105
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ins_i,
   input wire logic [KEY_W-1:0] ins_key_i,
   input wire logic look_i,
   input wire logic [KEY_W-1:0] look_key_i,
   output logic hit_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width.

   // The round robin pointer needs a power of two depth.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("pmf_req_table: DEPTH must be a power of two of at least 2");
   end

   logic [DEPTH-1:0] vld; // Entry holds a request.
   logic [DEPTH-1:0] next_vld;
   logic [KEY_W-1:0] key [DEPTH]; // Stored request keys.
   logic [KEY_W-1:0] next_key [DEPTH];
   logic [PW-1:0] ptr; // Oldest entry, replaced next.
   logic [PW-1:0] next_ptr;
   logic next_hit;

   // Search every entry and store a new request over the oldest one.
   always_comb begin
      next_vld = vld;
      next_key = key;
      next_ptr = ptr;
      next_hit = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         if (look_i && vld[i] && key[i] == look_key_i) begin
            next_hit = 1'b1; // [R9]
         end
      end
      if (ins_i) begin
         next_vld[ptr] = 1'b1; // [R9]
         next_key[ptr] = ins_key_i;
         next_ptr = ptr + 1'b1;
      end
   end

   // Register the table state.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vld <= '0;
         ptr <= '0;
         hit_o <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            key[i] <= '0;
         end
      end else begin
         vld <= next_vld;
         key <= next_key;
         ptr <= next_ptr;
         hit_o <= next_hit;
      end
   end

   // A request is found by a lookup in the very next cycle.
   req_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
      ins_i ##1 (look_i && look_key_i == $past(ins_key_i)) |=> hit_o)
      else $error("stored request not found");

endmodule // pmf_req_table

/* File: hw/pmf_top.sv */
`timescale 1ns/1ns
// PTP message filter with AXI4-Lite configuration registers.
module pmf_top #(
   parameter int REQ_DEPTH = 4
) (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic [pmf_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [pmf_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic MSG_VALID_I,
   input wire pmf_pkg::pmf_msg_s MSG_I,
   output logic RES_VALID_O,
   output pmf_pkg::pmf_res_s RES_O
);

   // ----------------------------------------------------------------
   // Register bus slave.
   // ----------------------------------------------------------------
   logic aw_hold, next_aw_hold; // Write address taken, not yet used.
   logic [pmf_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_hold, next_w_hold; // Write data taken, not yet used.
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic [pmf_pkg::CFG_W-1:0] cfg, next_cfg; // Filter configuration.
   logic bmc_done, next_bmc_done; // Best master clock determined.
   logic [pmf_pkg::VER_W-1:0] exp_ver, next_exp_ver; // Expected version.
   logic [pmf_pkg::DOM_W-1:0] expected_domain_number, next_expected_domain_number;
   logic [pmf_pkg::CNT_W-1:0] fwd_cnt, next_fwd_cnt; // Forwarded messages.
   logic [pmf_pkg::CNT_W-1:0] drop_cnt, next_drop_cnt; // Dropped messages.
   logic wr_go; // Both halves of a write are held.

   // A channel is ready while its half is not held and no response waits.
   assign S_AXI_AWREADY_O = !aw_hold && !bvalid;
   assign S_AXI_WREADY_O = !w_hold && !bvalid;
   assign S_AXI_ARREADY_O = !rvalid;
   assign S_AXI_BVALID_O = bvalid;
   assign S_AXI_BRESP_O = bresp;
   assign S_AXI_RVALID_O = rvalid;
   assign S_AXI_RRESP_O = rresp;
   assign S_AXI_RDATA_O = rdata;
   assign wr_go = aw_hold && w_hold && !bvalid;

   // Catch address and data in any order, then write and answer.
   always_comb begin
      next_aw_hold = aw_hold;
      next_aw_addr = aw_addr;
      next_w_hold = w_hold;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_cfg = cfg;
      next_bmc_done = bmc_done;
      next_exp_ver = exp_ver;
      next_expected_domain_number = expected_domain_number;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         next_aw_hold = 1'b1;
         next_aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         next_w_hold = 1'b1;
         next_w_data = S_AXI_WDATA_I;
         next_w_strb = S_AXI_WSTRB_I;
      end
      if (bvalid && S_AXI_BREADY_I) begin
         next_bvalid = 1'b0;
      end
      if (wr_go) begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = pmf_pkg::RESP_OKAY;
         case (aw_addr)
            pmf_pkg::ADDR_CFG: begin
               if (w_strb[0]) next_cfg[7:0] = w_data[7:0];
               if (w_strb[1]) next_cfg[8] = w_data[8];
            end
            pmf_pkg::ADDR_CTRL: begin
               if (w_strb[0]) next_bmc_done = w_data[0];
            end
            pmf_pkg::ADDR_DOMVER: begin
               if (w_strb[0]) next_expected_domain_number = w_data[7:0]; // [R8]
               if (w_strb[1]) next_exp_ver = w_data[11:8]; // [R7]
            end
            pmf_pkg::ADDR_STAT: begin
               // Counters only read; the write is accepted and ignored.
            end
            default: begin
               next_bresp = pmf_pkg::RESP_SLVERR; // Unmapped address.
            end
         endcase
      end
   end

   // Read path: one word per address, answered the cycle after it is taken.
   always_comb begin
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (rvalid && S_AXI_RREADY_I) begin
         next_rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         next_rvalid = 1'b1;
         next_rresp = pmf_pkg::RESP_OKAY;
         next_rdata = '0;
         case (S_AXI_ARADDR_I)
            pmf_pkg::ADDR_CFG: next_rdata[pmf_pkg::CFG_W-1:0] = cfg;
            pmf_pkg::ADDR_CTRL: next_rdata[0] = bmc_done;
            pmf_pkg::ADDR_DOMVER: next_rdata[15:0] = {4'h0, exp_ver, expected_domain_number};
            pmf_pkg::ADDR_STAT: next_rdata = {fwd_cnt, drop_cnt};
            default: next_rresp = pmf_pkg::RESP_SLVERR;
         endcase
      end
   end

   // Register the bus and configuration state.
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         aw_hold <= 1'b0;
         aw_addr <= '0;
         w_hold <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= pmf_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= pmf_pkg::RESP_OKAY;
         rdata <= '0;
         cfg <= pmf_pkg::CFG_RST;
         bmc_done <= 1'b0;
         exp_ver <= pmf_pkg::VER_RST;
         expected_domain_number <= pmf_pkg::DOM_RST;
      end else begin
         aw_hold <= next_aw_hold;
         aw_addr <= next_aw_addr;
         w_hold <= next_w_hold;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         cfg <= next_cfg;
         bmc_done <= next_bmc_done;
         exp_ver <= next_exp_ver;
         expected_domain_number <= next_expected_domain_number;
      end
   end

   // ----------------------------------------------------------------
   // Message pipeline: stage one looks up requests, stage two decides.
   // ----------------------------------------------------------------
   logic s1_vld, next_s1_vld; // Stage one holds a message.
   pmf_pkg::pmf_msg_s s1_msg, next_s1_msg;
   logic res_vld, next_res_vld;
   pmf_pkg::pmf_res_s res, next_res;
   logic is_req, is_resp, kind, hit; // Pairing classification and result.
   logic ver_ok, dom_ok, nom_drop, pair_drop;

   // Delay messages pair as kind 0, peer delay messages as kind 1.
   assign is_req = MSG_I.msg_type == pmf_pkg::MT_DREQ || MSG_I.msg_type == pmf_pkg::MT_PDREQ;
   assign is_resp = MSG_I.msg_type == pmf_pkg::MT_DRESP
      || MSG_I.msg_type == pmf_pkg::MT_PDRESP || MSG_I.msg_type == pmf_pkg::MT_PDRFUP;
   assign kind = MSG_I.msg_type != pmf_pkg::MT_DREQ && MSG_I.msg_type != pmf_pkg::MT_DRESP;

   pmf_req_table #(.DEPTH(REQ_DEPTH), .KEY_W(pmf_pkg::KEY_W)) u_table (
      .clk_i(CLK_I),
      .rst_n_i(RESET_N_I),
      .ins_i(MSG_VALID_I && is_req), // [R9]
      .ins_key_i({kind, MSG_I.domain, MSG_I.seq_id, MSG_I.src_port}),
      .look_i(MSG_VALID_I && is_resp),
      .look_key_i({kind, MSG_I.domain, MSG_I.seq_id, MSG_I.src_port}),
      .hit_o(hit)
   );

   // Each filter condition, worked out on the stage one message.
   always_comb begin
      ver_ok = s1_msg.version == exp_ver; // [R7]
      dom_ok = !cfg[pmf_pkg::CFG_DOM_CHK] || s1_msg.domain == expected_domain_number; // [R4]
      nom_drop = cfg[pmf_pkg::CFG_DROP_NOM] && !bmc_done // [R3]
         && (s1_msg.msg_type == pmf_pkg::MT_SYNC || s1_msg.msg_type == pmf_pkg::MT_FUP
         || s1_msg.msg_type == pmf_pkg::MT_DREQ);
      pair_drop = 1'b0;
      if (cfg[pmf_pkg::CFG_DREQ_PAIR] && s1_msg.msg_type == pmf_pkg::MT_DRESP && !hit) begin
         pair_drop = 1'b1; // [R1]
      end
      if (cfg[pmf_pkg::CFG_PDREQ_PAIR] && !hit && (s1_msg.msg_type == pmf_pkg::MT_PDRESP
         || s1_msg.msg_type == pmf_pkg::MT_PDRFUP)) begin
         pair_drop = 1'b1; // [R2]
      end
   end

   // Verdict, checksum choice and counters.
   always_comb begin
      next_s1_vld = MSG_VALID_I;
      next_s1_msg = MSG_VALID_I ? MSG_I : s1_msg;
      next_res_vld = s1_vld;
      next_res = res;
      next_fwd_cnt = fwd_cnt;
      next_drop_cnt = drop_cnt;
      if (s1_vld) begin
         next_res.fwd = ver_ok && dom_ok && !nom_drop && !pair_drop;
         // Capture each forwarded message; with domain checking on, only the checked domain.
         next_res.ts_capture = next_res.fwd; // [R8]
         if (s1_msg.is_ipv6) begin
            next_res.csum = s1_msg.csum_calc; // [R6]
         end else if (s1_msg.csum_in == 16'h0000) begin
            next_res.csum = 16'h0000; // [R6]
         end else if (!s1_msg.modified) begin
            next_res.csum = s1_msg.csum_in;
         end else if (cfg[pmf_pkg::CFG_CSUM_EN]) begin
            next_res.csum = s1_msg.csum_calc; // [R5]
         end else begin
            next_res.csum = 16'h0000; // [R5]
         end
         if (next_res.fwd) begin
            next_fwd_cnt = fwd_cnt + 1'b1;
         end else begin
            next_drop_cnt = drop_cnt + 1'b1;
         end
      end
   end

   assign RES_VALID_O = res_vld;
   assign RES_O = res;

   // Register the pipeline.
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         s1_vld <= 1'b0;
         s1_msg <= '0;
         res_vld <= 1'b0;
         res <= '0;
         fwd_cnt <= '0;
         drop_cnt <= '0;
      end else begin
         s1_vld <= next_s1_vld;
         s1_msg <= next_s1_msg;
         res_vld <= next_res_vld;
         res <= next_res;
         fwd_cnt <= next_fwd_cnt;
         drop_cnt <= next_drop_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);

   ver_drop_a: assert property (MSG_VALID_I && MSG_I.version != exp_ver // [R7]
      && !wr_go ##1 !wr_go |=> RES_VALID_O && !RES_O.fwd) else $error("bad version passed");
   dom_drop_a: assert property (s1_vld && cfg[pmf_pkg::CFG_DOM_CHK] // [R4]
      && s1_msg.domain != expected_domain_number |=> !RES_O.fwd) else $error("bad domain passed");
   nom_drop_a: assert property (s1_vld && !bmc_done && cfg[pmf_pkg::CFG_DROP_NOM] // [R3]
      && s1_msg.msg_type == pmf_pkg::MT_SYNC |=> !RES_O.fwd) else $error("sync passed");
   dresp_pair_a: assert property (s1_vld && cfg[pmf_pkg::CFG_DREQ_PAIR] && !hit // [R1]
      && s1_msg.msg_type == pmf_pkg::MT_DRESP |=> !RES_O.fwd) else $error("lone resp passed");
   presp_pair_a: assert property (s1_vld && cfg[pmf_pkg::CFG_PDREQ_PAIR] && !hit // [R2]
      && s1_msg.msg_type == pmf_pkg::MT_PDRESP |=> !RES_O.fwd) else $error("lone pdresp passed");
   csum_zero_a: assert property (s1_vld && !s1_msg.is_ipv6 && s1_msg.csum_in == 16'h0000 // [R6]
      |=> RES_O.csum == 16'h0000) else $error("zero checksum changed");
   csum_v6_a: assert property (MSG_VALID_I && MSG_I.is_ipv6 // [R6]
      |-> ##2 RES_O.csum == $past(MSG_I.csum_calc, 2)) else $error("ipv6 checksum stale");
   csum_off_a: assert property (s1_vld && !s1_msg.is_ipv6 && s1_msg.modified // [R5]
      && s1_msg.csum_in != 16'h0000 && !cfg[pmf_pkg::CFG_CSUM_EN] |=> RES_O.csum == 16'h0000)
      else $error("checksum not cleared");
   capture_a: assert property (RES_VALID_O && RES_O.ts_capture |-> RES_O.fwd // [R8]
      && $past(s1_msg.version == exp_ver)) else $error("capture of dropped message");
   wr_resp_a: assert property (wr_go |=> S_AXI_BVALID_O) else $error("write not answered");

   fwd_c: cover property (RES_VALID_O && RES_O.fwd);
   pair_c: cover property (s1_vld && hit ##1 RES_O.fwd);
   drop_c: cover property (s1_vld && pair_drop);
   wr_c: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);

endmodule // pmf_top

/* File: include/pmf_pkg.sv */
// What this block does
// R1 - Delay_Resp forwarded only when matching Delay_Req seen
// R2 - Pdelay responses forwarded only when matching Pdelay_Req
// R3 - Drop Sync, Follow_Up, Delay_Req until master chosen
// R4 - Domain check forwards matching, drops mismatching messages
// R5 - Modified IPv4 checksum recomputed, else written zero
// R6 - Zero IPv4 checksum kept; IPv6 always updated
// R7 - Four-bit expected version, mismatching messages dropped
// R8 - Eight-bit domain gates timestamp capture when checking
// R9 - Remember outstanding requests for response pairing
package pmf_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses of 32-bit words.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16; // Register bus address width.
   localparam int IDX_CFG = 16'h0516, IDX_CTRL = 16'h0514; // Word indices.
   localparam int IDX_DOMVER = 16'h0518, IDX_STAT = 16'h051c;
   localparam logic [ADDR_W-1:0] ADDR_CFG = ADDR_W'(IDX_CFG * 4); // Filter config.
   localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * 4); // Master status.
   localparam logic [ADDR_W-1:0] ADDR_DOMVER = ADDR_W'(IDX_DOMVER * 4); // Domain and version.
   localparam logic [ADDR_W-1:0] ADDR_STAT = ADDR_W'(IDX_STAT * 4); // Message counters.

   // ----------------------------------------------------------------
   // Field layouts and reset values.
   // ----------------------------------------------------------------
   localparam int CFG_W = 9; // Stored filter config bits.
   localparam logic [CFG_W-1:0] CFG_RST = 9'h004; // Checksum enable set.
   localparam int CFG_DREQ_PAIR = 8; // Delay pairing enable.
   localparam int CFG_PDREQ_PAIR = 7; // Peer delay pairing enable.
   localparam int CFG_DROP_NOM = 5; // Drop without master.
   localparam int CFG_DOM_CHK = 4; // Domain checking.
   localparam int CFG_CSUM_EN = 2; // Egress checksum regeneration.
   localparam int VER_W = 4; // Expected version width.
   localparam int DOM_W = 8; // Expected domain width.
   localparam int DV_VER_LSB = 8; // Version field position.
   localparam logic [VER_W-1:0] VER_RST = 4'h2; // Version reset value.
   localparam logic [DOM_W-1:0] DOM_RST = 8'h00; // Domain reset value.
   localparam int CNT_W = 16; // Counter width.

   // ----------------------------------------------------------------
   // Message types and bus responses.
   // ----------------------------------------------------------------
   localparam logic [3:0] MT_SYNC = 4'h0; // Sync.
   localparam logic [3:0] MT_DREQ = 4'h1; // Delay_Req.
   localparam logic [3:0] MT_PDREQ = 4'h2; // Pdelay_Req.
   localparam logic [3:0] MT_PDRESP = 4'h3; // Pdelay_Resp.
   localparam logic [3:0] MT_FUP = 4'h8; // Follow_Up.
   localparam logic [3:0] MT_DRESP = 4'h9; // Delay_Resp.
   localparam logic [3:0] MT_PDRFUP = 4'ha; // Pdelay_Resp_Follow_Up.
   localparam logic [1:0] RESP_OKAY = 2'h0; // Bus OKAY.
   localparam logic [1:0] RESP_SLVERR = 2'h2; // Bus SLVERR.
   localparam int KEY_W = 105; // Kind, domain, sequence, source port.

   // Parsed header of one received PTP message.
   typedef struct packed {
      logic [3:0] msg_type;
      logic [VER_W-1:0] version;
      logic [DOM_W-1:0] domain;
      logic [15:0] seq_id;
      logic [79:0] src_port;
      logic is_ipv6;
      logic modified;
      logic [15:0] csum_in;
      logic [15:0] csum_calc;
   } pmf_msg_s;

   // Verdict for one message.
   typedef struct packed {
      logic fwd;
      logic ts_capture;
      logic [15:0] csum;
   } pmf_res_s;

endpackage

/* File: verif/pmf_port_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Ingress port model
// ----------------------------------------------------------------
// Hands parsed messages to the filter, one per send call or two per send2 call, with no back pressure.
module pmf_port_model (
   input wire logic clk_i,
   output logic msg_valid_o,
   output pmf_pkg::pmf_msg_s msg_o
);
   // Idle until the first message is offered.
   initial begin
      msg_valid_o = 1'b0;
      msg_o = {146{1'b0}};
   end
   // Offers one message for a single edge, then scrambles the idle bus.
   task automatic send(input pmf_pkg::pmf_msg_s m);
      @(posedge clk_i);
      msg_valid_o <= 1'b1;
      msg_o <= m;
      @(posedge clk_i);
      msg_valid_o <= 1'b0;
      msg_o <= ~m;
   endtask
   // Offers a then b on consecutive edges.
   task automatic send2(input pmf_pkg::pmf_msg_s a, b);
      @(posedge clk_i);
      msg_valid_o <= 1'b1;
      msg_o <= a;
      @(posedge clk_i);
      msg_o <= b;
      @(posedge clk_i);
      msg_valid_o <= 1'b0;
      msg_o <= ~b;
   endtask
endmodule // pmf_port_model

/* File: verif/pmf_tb.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Self-checking bench for the message filter
// ----------------------------------------------------------------
module testbench;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready; // Bus controls.
   logic awready, wready, bvalid, arready, rvalid, rvld; // Design handshakes.
   logic [15:0] awaddr, araddr; // Byte addresses.
   logic [31:0] wdata, rdata; // Data words.
   logic [1:0] bresp, rresp; // Response codes.
   logic mvalid; // Message strobe from the port model.
   pmf_pkg::pmf_msg_s mdata; // Message from the port model.
   pmf_pkg::pmf_res_s res; // Verdict from the design.
   int mismatches, cmp_count; // Tallies.
   // Design under test.
   pmf_top #(.REQ_DEPTH(4)) uut (.CLK_I(clk), .RESET_N_I(rst_n),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .MSG_VALID_I(mvalid),
      .MSG_I(mdata), .RES_VALID_O(rvld), .RES_O(res));
   // Ingress side of the filter.
   pmf_port_model port (.clk_i(clk), .msg_valid_o(mvalid), .msg_o(mdata));
   // Free-running 125 MHz clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Cuts a hung run short.
   initial begin
      #400000;
      mismatches++;
      test_done();
   end
   // Prints the tallies and the verdict, then ends the run.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Compares one bus word.
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Compares one message verdict.
   task automatic chk_r(input pmf_pkg::pmf_res_s g, input pmf_pkg::pmf_res_s e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Bus write: address and data offered together, each dropped once taken.
   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // Bus read: address held until taken, data taken with the answer.
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // Write that must be accepted.
   task automatic wr_ok(input logic [15:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk_w({30'h0, r}, {30'h0, pmf_pkg::RESP_OKAY});
   endtask
   // Read compared with an expected word and response.
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk_w(d, e);
      chk_w({30'h0, r}, {30'h0, er});
   endtask
   // Builds an unmodified IPv4 message, checksum nonzero.
   function automatic pmf_pkg::pmf_msg_s mk(input logic [3:0] t, input logic [3:0] v,
         input logic [7:0] d, input logic [15:0] s);
      mk = {146{1'b0}};
      mk.msg_type = t;
      mk.version = v;
      mk.domain = d;
      mk.seq_id = s;
      mk.src_port = 80'h00a1_b2c3_d4e5_f607_1829;
      mk.csum_in = 16'h1234;
      mk.csum_calc = 16'h5678;
   endfunction
   // Sends one message and judges the verdict two cycles later.
   task automatic msg(input pmf_pkg::pmf_msg_s m, input logic f, input logic [15:0] cs);
      pmf_pkg::pmf_res_s e;
      e.fwd = f;
      e.ts_capture = f;
      e.csum = cs;
      port.send(m);
      @(posedge clk);
      #1;
      chk_w({31'h0, rvld}, 32'h1);
      chk_r(res, e);
   endtask
   // Plain forwarded or dropped verdict with the received checksum kept.
   task automatic fw(input logic [3:0] t, input logic [3:0] v, input logic [7:0] d,
         input logic [15:0] s, input logic f);
      msg(mk(t, v, d, s), f, 16'h1234);
   endtask
   // Reset values, read-only bits and an unmapped place.
   task automatic t_regs();
      logic [1:0] r;
      rd_chk(pmf_pkg::ADDR_CFG, 32'h4, pmf_pkg::RESP_OKAY);
      rd_chk(pmf_pkg::ADDR_DOMVER, 32'h200, pmf_pkg::RESP_OKAY);
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'hffff_ffff);
      rd_chk(pmf_pkg::ADDR_DOMVER, 32'hfff, pmf_pkg::RESP_OKAY);
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'h200);
      wr(16'h0600, 32'h1, r);
      chk_w({30'h0, r}, {30'h0, pmf_pkg::RESP_SLVERR});
      rd_chk(16'h0600, 32'h0, pmf_pkg::RESP_SLVERR);
   endtask
   // Version match forwards, any other version drops.
   task automatic t_version();
      fw(pmf_pkg::MT_SYNC, 4'h2, 8'h00, 16'h1, 1'b1);
      fw(pmf_pkg::MT_SYNC, 4'h1, 8'h00, 16'h2, 1'b0);
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'h300);
      fw(pmf_pkg::MT_FUP, 4'h3, 8'h00, 16'h3, 1'b1);
      fw(pmf_pkg::MT_FUP, 4'h2, 8'h00, 16'h4, 1'b0);
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'h200);
   endtask
   // Domain ignored while checking is off, enforced once it is on.
   task automatic t_domain();
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'h205);
      fw(pmf_pkg::MT_SYNC, 4'h2, 8'h09, 16'h5, 1'b1);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h14);
      fw(pmf_pkg::MT_SYNC, 4'h2, 8'h05, 16'h6, 1'b1);
      fw(pmf_pkg::MT_SYNC, 4'h2, 8'h06, 16'h7, 1'b0);
      fw(pmf_pkg::MT_FUP, 4'h2, 8'h04, 16'h8, 1'b0);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h4);
      wr_ok(pmf_pkg::ADDR_DOMVER, 32'h200);
   endtask
   // Sync, Follow_Up and Delay_Req dropped until a master is chosen.
   task automatic t_nomaster();
      logic [3:0] ty [3];
      ty = '{pmf_pkg::MT_SYNC, pmf_pkg::MT_FUP, pmf_pkg::MT_DREQ};
      wr_ok(pmf_pkg::ADDR_CFG, 32'h24);
      foreach (ty[i]) fw(ty[i], 4'h2, 8'h00, 16'h10, 1'b0);
      fw(pmf_pkg::MT_PDREQ, 4'h2, 8'h00, 16'h11, 1'b1);
      wr_ok(pmf_pkg::ADDR_CTRL, 32'h1);
      rd_chk(pmf_pkg::ADDR_CTRL, 32'h1, pmf_pkg::RESP_OKAY);
      foreach (ty[i]) fw(ty[i], 4'h2, 8'h00, 16'h12, 1'b1);
      wr_ok(pmf_pkg::ADDR_CTRL, 32'h0);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h4);
   endtask
   // Delay_Resp forwarded only after a Delay_Req with the same key.
   task automatic t_dpair();
      wr_ok(pmf_pkg::ADDR_CFG, 32'h104);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h100, 1'b0);
      fw(pmf_pkg::MT_DREQ, 4'h2, 8'h00, 16'h100, 1'b1);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h100, 1'b1);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h101, 1'b0);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h03, 16'h100, 1'b0);
      fw(pmf_pkg::MT_PDREQ, 4'h2, 8'h00, 16'h200, 1'b1);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h200, 1'b0);
      fw(pmf_pkg::MT_PDRESP, 4'h2, 8'h00, 16'h201, 1'b1);
      port.send2(mk(pmf_pkg::MT_DREQ, 4'h2, 8'h00, 16'h500),
         mk(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h500));
      @(posedge clk);
      #1;
      chk_w({31'h0, rvld}, 32'h1);
      chk_r(res, {2'b11, 16'h1234});
   endtask
   // Peer delay responses forwarded only after a matching Pdelay_Req.
   task automatic t_pdpair();
      wr_ok(pmf_pkg::ADDR_CFG, 32'h84);
      fw(pmf_pkg::MT_PDRESP, 4'h2, 8'h00, 16'h300, 1'b0);
      fw(pmf_pkg::MT_PDRFUP, 4'h2, 8'h00, 16'h300, 1'b0);
      fw(pmf_pkg::MT_PDREQ, 4'h2, 8'h00, 16'h300, 1'b1);
      fw(pmf_pkg::MT_PDRESP, 4'h2, 8'h00, 16'h300, 1'b1);
      fw(pmf_pkg::MT_PDRFUP, 4'h2, 8'h00, 16'h300, 1'b1);
      fw(pmf_pkg::MT_DRESP, 4'h2, 8'h00, 16'h301, 1'b1);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h4);
   endtask
   // Egress checksum with regeneration on, then off.
   task automatic t_csum();
      pmf_pkg::pmf_msg_s m, z, v6;
      m = mk(pmf_pkg::MT_SYNC, 4'h2, 8'h00, 16'h400);
      m.modified = 1'b1;
      z = m;
      z.csum_in = 16'h0000;
      v6 = m;
      v6.is_ipv6 = 1'b1;
      msg(m, 1'b1, 16'h5678);
      msg(z, 1'b1, 16'h0000);
      msg(v6, 1'b1, 16'h5678);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h0);
      msg(m, 1'b1, 16'h0000);
      msg(z, 1'b1, 16'h0000);
      msg(v6, 1'b1, 16'h5678);
      fw(pmf_pkg::MT_SYNC, 4'h2, 8'h00, 16'h401, 1'b1);
      wr_ok(pmf_pkg::ADDR_CFG, 32'h4);
   endtask
   // Main sequence: reset, then every scenario in turn.
   initial begin
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 16'h0000;
      araddr = 16'h0000;
      wdata = 32'h0;
      mismatches = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_version();
      t_domain();
      t_nomaster();
      t_dpair();
      t_pdpair();
      t_csum();
      rd_chk(pmf_pkg::ADDR_STAT, 32'h0019_000d, pmf_pkg::RESP_OKAY);
      test_done();
   end
endmodule // testbench
